// ---- verilog/flash_cmd_pkg.sv ----
`default_nettype none
package flash_cmd_pkg;

  localparam int CLK_PERIOD_NS = 8;

  // instruction codes
  localparam logic [7:0] OP_RESUME   = 8'h7A;
  localparam logic [7:0] OP_SUSPEND  = 8'h75;
  localparam logic [7:0] OP_PDOWN    = 8'hB9;
  localparam logic [7:0] OP_RELEASE  = 8'hAB;
  localparam logic [7:0] OP_ID       = 8'h90;
  localparam logic [7:0] OP_ID_DUAL  = 8'h92;
  localparam logic [7:0] OP_ID_QUAD  = 8'h94;
  localparam logic [7:0] OP_UID      = 8'h4B;

  // frame layout
  localparam int         BYTE_BITS          = 8;
  localparam int         ADDR_BITS          = 24;
  localparam int         MODE_BITS          = 8;
  localparam int         QUAD_DUMMY_CLKS    = 4;
  localparam int         RELEASE_DUMMY_BITS = 24;
  localparam int         UID_DUMMY_BITS     = 32;
  localparam int         UID_BITS           = 64;
  localparam logic [3:0] MODE_UPPER         = 4'hF;

  // timing in ns; figures not given elsewhere are plain defaults
  localparam int RESUME_BUSY_NS = 200;
  localparam int TDP_NS         = 3000;
  localparam int RELEASE_TIME_NS       = 3000;
  localparam int RELEASE_WITH_ID_TIME_NS       = 1800;
  localparam int SUSPEND_LATENCY_TIME_NS        = 20000;
  localparam int CS_HIGH_NS     = 50;

  // least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  // longest time rounds down
  localparam int RESUME_BUSY_CYC = RESUME_BUSY_NS / CLK_PERIOD_NS;
  localparam int TDP_CYC         = ns_to_cyc(TDP_NS);
  localparam int RELEASE_TIME_CYC       = ns_to_cyc(RELEASE_TIME_NS);
  localparam int RELEASE_WITH_ID_TIME_CYC       = ns_to_cyc(RELEASE_WITH_ID_TIME_NS);
  localparam int SUSPEND_LATENCY_TIME_CYC        = ns_to_cyc(SUSPEND_LATENCY_TIME_NS);
  localparam int CS_HIGH_CYC     = ns_to_cyc(CS_HIGH_NS);

  // log2 of lanes used for address, mode and id data
  function automatic logic [1:0] lane_shift(input logic [7:0] op);
    if (op == OP_ID_DUAL) begin
      return 2'h1;
    end else if (op == OP_ID_QUAD) begin
      return 2'h2;
    end
    return 2'h0;
  endfunction : lane_shift

endpackage : flash_cmd_pkg
`default_nettype wire

// ---- verilog/flash_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface flash_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io;

  // weak pull-up when nobody drives a lane
  assign io = (dev_io_oe & dev_io_o) | (~dev_io_oe & host_io_oe & host_io_o)
            | (~dev_io_oe & ~host_io_oe);

  modport host (output cs_n, output sclk, output host_io_o, output host_io_oe, input io);
  modport dev  (input cs_n, input sclk, input io, output dev_io_o, output dev_io_oe);
endinterface : flash_link_if
`default_nettype wire

// ---- verilog/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  always_comb begin
    meta_d = pin_in;
    out_d  = meta_q;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= RESET_VAL;
      out_q  <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      out_q  <= out_d;
    end
  end

  assign pin_out = out_q;
endmodule : pin_sync
`default_nettype wire

// ---- verilog/flash_id_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_id_dev
  import flash_cmd_pkg::*;
#(
  parameter logic [7:0]  MFR_ID       = 8'hA5,                  // arbitrary value
  parameter logic [7:0]  DEV_ID       = 8'h3C,                  // arbitrary value
  parameter logic [63:0] UNIQUE_ID    = 64'h0123_4567_89AB_CDEF, // arbitrary value
  parameter int          TDP_CYCLES   = TDP_CYC,
  parameter int          RELEASE_TIME_CYCLES = RELEASE_TIME_CYC,
  parameter int          RELEASE_WITH_ID_TIME_CYCLES = RELEASE_WITH_ID_TIME_CYC
)(
  // clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // serial link
  flash_link_if.dev link,
  // erase/program engine
  input  wire logic engine_busy,
  input  wire logic power_lost,
  output logic      suspend_req,
  output logic      resume_req,
  // status
  output logic      suspend_flag,
  output logic      powered_down
);
  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_MODE, PH_DUMMY, PH_OUT, PH_SKIP} phase_type;
  typedef enum logic [1:0] {PW_ON, PW_ENTER, PW_DOWN, PW_WAKE} power_type;
  typedef enum logic [1:0] {SRC_DEV, SRC_PAIR, SRC_UID} src_type;

  logic [5:0]  pins_s;
  logic        cs_s;
  logic        sclk_s;
  logic [3:0]  io_s;
  logic        cs_prev_q, sclk_prev_q;
  logic        cs_rise, sclk_rise, sclk_fall;
  phase_type   phase_q, phase_d;
  power_type   pwr_q, pwr_d;
  src_type     src_q, src_d;
  logic [5:0]  cnt_q, cnt_d, len_q, len_d;
  logic [1:0]  lsh_q, lsh_d;
  logic [2:0]  lanes;
  logic [23:0] sr_q, sr_d, sr_in;
  logic [3:0]  in_bits;
  logic [7:0]  cmd_q, cmd_d, c;
  logic        got_q, got_d, exact_q, exact_d, alt_q, alt_d;
  logic [63:0] tx_q, tx_d;
  logic [6:0]  txn_q, txn_d;
  logic [3:0]  io_o_q, io_o_d, io_oe_q, io_oe_d;
  logic [15:0] wait_q, wait_d;
  logic        sus_q, sus_d, susp_req_q, susp_req_d, res_req_q, res_req_d;

  pin_sync #(
    .WIDTH     (6),
    .RESET_VAL (6'h2F)
  ) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pin_in  ({link.cs_n, link.sclk, link.io}),
    .pin_out (pins_s)
  );

  assign cs_s      = pins_s[5];
  assign sclk_s    = pins_s[4];
  assign io_s      = pins_s[3:0];
  assign cs_rise   = cs_s & ~cs_prev_q;
  assign sclk_rise = ~cs_s & sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~cs_s & ~sclk_s & sclk_prev_q;
  assign lanes     = 3'h1 << lsh_q;

  // id is a constant, no write path
  function automatic logic [63:0] unit(input src_type s, input logic sel);
    if (s == SRC_UID) begin
      return UNIQUE_ID;
    end else if (s == SRC_PAIR && !sel) begin
      return {MFR_ID, 56'h0};
    end
    return {DEV_ID, 56'h0};
  endfunction : unit

  function automatic logic [6:0] unit_len(input src_type s);
    return (s == SRC_UID) ? 7'(UID_BITS) : 7'(BYTE_BITS);
  endfunction : unit_len

  always_comb begin
    phase_d    = phase_q;
    pwr_d      = pwr_q;
    src_d      = src_q;
    cnt_d      = cnt_q;
    len_d      = len_q;
    lsh_d      = lsh_q;
    sr_d       = sr_q;
    cmd_d      = cmd_q;
    got_d      = got_q;
    exact_d    = exact_q;
    alt_d      = alt_q;
    tx_d       = tx_q;
    txn_d      = txn_q;
    io_o_d     = io_o_q;
    io_oe_d    = io_oe_q;
    wait_d     = wait_q;
    sus_d      = sus_q;
    susp_req_d = 1'b0;
    res_req_d  = 1'b0;
    case (lsh_q)
      2'h0:    in_bits = {3'h0, io_s[0]};
      2'h1:    in_bits = {2'h0, io_s[1:0]};
      default: in_bits = io_s;
    endcase
    sr_in = (sr_q << lanes) | {20'h0, in_bits};
    c     = sr_in[7:0];
    if (pwr_q == PW_ENTER || pwr_q == PW_WAKE) begin
      wait_d = wait_q - 16'h1;
      if (wait_q == 16'h1) begin
        pwr_d = (pwr_q == PW_ENTER) ? PW_DOWN : PW_ON;
      end
    end
    if (cs_s) begin
      if (cs_rise && got_q) begin
        // pdown, resume and suspend need exactly eight bits before cs rises
        if (cmd_q == OP_PDOWN && exact_q && pwr_q == PW_ON) begin
          pwr_d  = PW_ENTER;
          wait_d = 16'(TDP_CYCLES);
        end else if (cmd_q == OP_RESUME && exact_q && pwr_q == PW_ON && sus_q && !engine_busy) begin
          sus_d     = 1'b0;
          res_req_d = 1'b1;
        end else if (cmd_q == OP_SUSPEND && exact_q && pwr_q == PW_ON && !sus_q && engine_busy) begin
          sus_d      = 1'b1;
          susp_req_d = 1'b1;
        end else if (cmd_q == OP_RELEASE && pwr_q == PW_DOWN && !engine_busy) begin
          pwr_d  = PW_WAKE;
          wait_d = exact_q ? 16'(RELEASE_TIME_CYCLES) : 16'(RELEASE_WITH_ID_TIME_CYCLES);
        end
      end
      phase_d = PH_CMD;
      cnt_d   = 6'h0;
      lsh_d   = 2'h0;
      got_d   = 1'b0;
      exact_d = 1'b0;
      io_oe_d = 4'h0;
    end else if (sclk_rise) begin
      exact_d = 1'b0;
      cnt_d   = cnt_q + 6'h1;
      sr_d    = sr_in;
      case (phase_q)
        PH_CMD: begin
          if (cnt_q == 6'(BYTE_BITS - 1)) begin
            cnt_d   = 6'h0;
            cmd_d   = c;
            got_d   = 1'b1;
            exact_d = 1'b1;
            phase_d = PH_SKIP;
            if (c == OP_RELEASE && !engine_busy && (pwr_q == PW_ON || pwr_q == PW_DOWN)) begin
              phase_d = PH_DUMMY;
              len_d   = 6'(RELEASE_DUMMY_BITS);
              src_d   = SRC_DEV;
            end else if (pwr_q == PW_ON && (c == OP_ID || c == OP_ID_DUAL || c == OP_ID_QUAD)) begin
              phase_d = PH_ADDR;
              lsh_d   = lane_shift(c);
              len_d   = 6'(ADDR_BITS >> lane_shift(c));
              src_d   = SRC_PAIR;
            end else if (pwr_q == PW_ON && c == OP_UID) begin
              phase_d = PH_DUMMY;
              len_d   = 6'(UID_DUMMY_BITS);
              src_d   = SRC_UID;
            end
          end
        end
        PH_ADDR: begin
          if (cnt_q == len_q - 6'h1) begin
            cnt_d = 6'h0;
            // odd address starts with device id
            alt_d = sr_in[0];
            if (cmd_q == OP_ID) begin
              phase_d = PH_OUT;
              tx_d    = unit(src_q, sr_in[0]);
              txn_d   = unit_len(src_q);
            end else begin
              phase_d = PH_MODE;
              len_d   = 6'(MODE_BITS >> lsh_q);
            end
          end
        end
        PH_MODE: begin
          if (cnt_q == len_q - 6'h1) begin
            cnt_d = 6'h0;
            if (cmd_q == OP_ID_QUAD) begin
              phase_d = PH_DUMMY;
              len_d   = 6'(QUAD_DUMMY_CLKS);
            end else begin
              phase_d = PH_OUT;
              tx_d    = unit(src_q, alt_q);
              txn_d   = unit_len(src_q);
            end
          end
        end
        PH_DUMMY: begin
          if (cnt_q == len_q - 6'h1) begin
            cnt_d   = 6'h0;
            phase_d = PH_OUT;
            tx_d    = unit(src_q, alt_q);
            txn_d   = unit_len(src_q);
          end
        end
        default: ;
      endcase
    end else if (sclk_fall && phase_q == PH_OUT) begin
      case (lsh_q)
        2'h0: begin
          io_o_d  = {2'h0, tx_q[63], 1'b0};
          io_oe_d = 4'h2;
        end
        2'h1: begin
          io_o_d  = {2'h0, tx_q[63:62]};
          io_oe_d = 4'h3;
        end
        default: begin
          io_o_d  = tx_q[63:60];
          io_oe_d = 4'hF;
        end
      endcase
      tx_d  = tx_q << lanes;
      txn_d = txn_q - {4'h0, lanes};
      if (txn_q == {4'h0, lanes}) begin
        alt_d = ~alt_q;
        tx_d  = unit(src_q, ~alt_q);
        txn_d = unit_len(src_q);
      end
    end
    if (power_lost) begin
      sus_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cs_prev_q   <= 1'b1;
      sclk_prev_q <= 1'b0;
      phase_q     <= PH_CMD;
      pwr_q       <= PW_ON;
      src_q       <= SRC_DEV;
      cnt_q       <= 6'h0;
      len_q       <= 6'h0;
      lsh_q       <= 2'h0;
      sr_q        <= 24'h0;
      cmd_q       <= 8'h0;
      got_q       <= 1'b0;
      exact_q     <= 1'b0;
      alt_q       <= 1'b0;
      tx_q        <= 64'h0;
      txn_q       <= 7'h0;
      io_o_q      <= 4'h0;
      io_oe_q     <= 4'h0;
      wait_q      <= 16'h0;
      sus_q       <= 1'b0;
      susp_req_q  <= 1'b0;
      res_req_q   <= 1'b0;
    end else begin
      cs_prev_q   <= cs_s;
      sclk_prev_q <= sclk_s;
      phase_q     <= phase_d;
      pwr_q       <= pwr_d;
      src_q       <= src_d;
      cnt_q       <= cnt_d;
      len_q       <= len_d;
      lsh_q       <= lsh_d;
      sr_q        <= sr_d;
      cmd_q       <= cmd_d;
      got_q       <= got_d;
      exact_q     <= exact_d;
      alt_q       <= alt_d;
      tx_q        <= tx_d;
      txn_q       <= txn_d;
      io_o_q      <= io_o_d;
      io_oe_q     <= io_oe_d;
      wait_q      <= wait_d;
      sus_q       <= sus_d;
      susp_req_q  <= susp_req_d;
      res_req_q   <= res_req_d;
    end
  end

  assign link.dev_io_o  = io_o_q;
  assign link.dev_io_oe = io_oe_q;
  assign suspend_req    = susp_req_q;
  assign resume_req     = res_req_q;
  assign suspend_flag   = sus_q;
  assign powered_down   = (pwr_q == PW_DOWN);
endmodule : flash_id_dev
`default_nettype wire

// ---- verilog/flash_id_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_id_host
  import flash_cmd_pkg::*;
#(
  parameter int SCLK_HALF    = 10,
  parameter int TDP_CYCLES   = TDP_CYC,
  parameter int RELEASE_TIME_CYCLES = RELEASE_TIME_CYC,
  parameter int RELEASE_WITH_ID_TIME_CYCLES = RELEASE_WITH_ID_TIME_CYC,
  parameter int SUSPEND_LATENCY_TIME_CYCLES  = SUSPEND_LATENCY_TIME_CYC
)(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // serial link
  flash_link_if.host      link,
  // command port
  input  wire logic       start,
  input  wire logic [7:0] op,
  input  wire logic [23:0] addr,
  input  wire logic [7:0] mode_bits,
  input  wire logic [7:0] rx_bytes,
  output logic            ready,
  // read data
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            done
);
  typedef enum logic [2:0] {H_IDLE, H_CMD, H_ADDR, H_MODE, H_DUMMY, H_READ, H_STOP, H_GAP}
    hstate_type;

  hstate_type  st_q, st_d, after_read;
  logic [3:0]  io_s;
  logic [7:0]  div_q, div_d, op_q, op_d, mode_q, mode_d, rxb_q, rxb_d;
  logic [7:0]  rx_sh_q, rx_sh_d, rx_sh_in, rx_data_q, rx_data_d;
  logic [23:0] addr_q, addr_d;
  logic [31:0] tx_q, tx_d;
  logic [10:0] cnt_q, cnt_d, plen;
  logic [1:0]  lsh_q, lsh_d;
  logic [2:0]  lanes;
  logic [3:0]  rxbit_q, rxbit_d, in_bits, io_o_q, io_o_d, io_oe_q, io_oe_d;
  logic [15:0] gap_q, gap_d;
  logic        sclk_q, sclk_d, cs_n_q, cs_n_d, rx_valid_q, rx_valid_d, done_q, done_d, half;

  pin_sync #(
    .WIDTH     (4),
    .RESET_VAL (4'hF)
  ) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pin_in  (link.io),
    .pin_out (io_s)
  );

  assign half  = (div_q == 8'(SCLK_HALF - 1));
  assign lanes = 3'h1 << lsh_q;
  assign after_read = (rxb_q != 8'h0) ? H_READ : H_STOP;

  function automatic logic [15:0] gap_for(input logic [7:0] o, input logic [7:0] n);
    if (o == OP_PDOWN) begin
      return 16'(TDP_CYCLES);
    end else if (o == OP_RELEASE) begin
      return (n == 8'h0) ? 16'(RELEASE_TIME_CYCLES) : 16'(RELEASE_WITH_ID_TIME_CYCLES);
    end else if (o == OP_RESUME) begin
      return 16'(SUSPEND_LATENCY_TIME_CYCLES);
    end
    return 16'(CS_HIGH_CYC);
  endfunction : gap_for

  always_comb begin
    case (st_q)
      H_CMD:   plen = 11'(BYTE_BITS);
      H_ADDR:  plen = 11'(ADDR_BITS >> lsh_q);
      H_MODE:  plen = 11'(MODE_BITS >> lsh_q);
      H_DUMMY: plen = (op_q == OP_RELEASE) ? 11'(RELEASE_DUMMY_BITS)
                    : (op_q == OP_UID) ? 11'(UID_DUMMY_BITS) : 11'(QUAD_DUMMY_CLKS);
      H_READ:  plen = {rxb_q, 3'h0} >> lsh_q;
      default: plen = 11'h1;
    endcase
    in_bits  = (lsh_q == 2'h0) ? {3'h0, io_s[1]} : (lsh_q == 2'h1) ? {2'h0, io_s[1:0]} : io_s;
    rx_sh_in = (rx_sh_q << lanes) | {4'h0, in_bits};
  end

  always_comb begin
    st_d       = st_q;
    div_d      = div_q;
    op_d       = op_q;
    mode_d     = mode_q;
    rxb_d      = rxb_q;
    addr_d     = addr_q;
    tx_d       = tx_q;
    cnt_d      = cnt_q;
    lsh_d      = lsh_q;
    rx_sh_d    = rx_sh_q;
    rxbit_d    = rxbit_q;
    io_o_d     = io_o_q;
    io_oe_d    = io_oe_q;
    gap_d      = gap_q;
    sclk_d     = sclk_q;
    cs_n_d     = cs_n_q;
    rx_data_d  = rx_data_q;
    rx_valid_d = 1'b0;
    done_d     = 1'b0;
    case (st_q)
      H_IDLE: begin
        if (start) begin
          st_d    = H_CMD;
          op_d    = op;
          addr_d  = addr;
          mode_d  = {MODE_UPPER, mode_bits[3:0]};
          rxb_d   = rx_bytes;
          lsh_d   = 2'h0;
          cnt_d   = 11'h0;
          div_d   = 8'h0;
          rxbit_d = 4'h0;
          cs_n_d  = 1'b0;
          io_o_d  = {3'h0, op[7]};
          io_oe_d = 4'h1;
          tx_d    = {op[6:0], 25'h0};
        end
      end
      H_GAP: begin
        gap_d = gap_q - 16'h1;
        if (gap_q == 16'h1) begin
          st_d   = H_IDLE;
          done_d = 1'b1;
        end
      end
      default: begin
        div_d = half ? 8'h0 : div_q + 8'h1;
        if (half) begin
          if (st_q == H_STOP) begin
            // cs rises with the falling edge half a clock after the last rising edge
            cs_n_d  = 1'b1;
            sclk_d  = 1'b0;
            io_oe_d = 4'h0;
            st_d    = H_GAP;
            gap_d   = gap_for(op_q, rxb_q);
          end else if (!sclk_q) begin
            sclk_d = 1'b1;
            cnt_d  = cnt_q + 11'h1;
            if (st_q == H_READ) begin
              rx_sh_d = rx_sh_in;
              rxbit_d = rxbit_q + {1'b0, lanes};
              if (rxbit_q + {1'b0, lanes} == 4'(BYTE_BITS)) begin
                rx_data_d  = rx_sh_in;
                rx_valid_d = 1'b1;
                rxbit_d    = 4'h0;
              end
            end
            if (cnt_q == plen - 11'h1) begin
              cnt_d = 11'h0;
              case (st_q)
                H_CMD: begin
                  if (op_q == OP_ID || op_q == OP_ID_DUAL || op_q == OP_ID_QUAD) begin
                    st_d  = H_ADDR;
                    lsh_d = lane_shift(op_q);
                    tx_d  = {addr_q, 8'h0};
                  end else if ((op_q == OP_RELEASE && rxb_q != 8'h0) || op_q == OP_UID) begin
                    st_d = H_DUMMY;
                  end else begin
                    st_d = H_STOP;
                  end
                end
                H_ADDR: begin
                  if (op_q != OP_ID) begin
                    st_d = H_MODE;
                    tx_d = {mode_q, 24'h0};
                  end else begin
                    st_d = after_read;
                  end
                end
                H_MODE:  st_d = (op_q == OP_ID_QUAD) ? H_DUMMY : after_read;
                H_DUMMY: st_d = after_read;
                default: st_d = H_STOP;
              endcase
            end
          end else begin
            sclk_d  = 1'b0;
            io_oe_d = 4'h0;
            if (st_q == H_CMD || st_q == H_ADDR || st_q == H_MODE) begin
              io_o_d  = (lsh_q == 2'h0) ? {3'h0, tx_q[31]}
                      : (lsh_q == 2'h1) ? {2'h0, tx_q[31:30]} : tx_q[31:28];
              io_oe_d = (lsh_q == 2'h0) ? 4'h1 : (lsh_q == 2'h1) ? 4'h3 : 4'hF;
              tx_d    = tx_q << lanes;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q       <= H_IDLE;
      div_q      <= 8'h0;
      op_q       <= 8'h0;
      mode_q     <= 8'h0;
      rxb_q      <= 8'h0;
      addr_q     <= 24'h0;
      tx_q       <= 32'h0;
      cnt_q      <= 11'h0;
      lsh_q      <= 2'h0;
      rx_sh_q    <= 8'h0;
      rxbit_q    <= 4'h0;
      io_o_q     <= 4'h0;
      io_oe_q    <= 4'h0;
      gap_q      <= 16'h0;
      sclk_q     <= 1'b0;
      cs_n_q     <= 1'b1;
      rx_data_q  <= 8'h0;
      rx_valid_q <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      st_q       <= st_d;
      div_q      <= div_d;
      op_q       <= op_d;
      mode_q     <= mode_d;
      rxb_q      <= rxb_d;
      addr_q     <= addr_d;
      tx_q       <= tx_d;
      cnt_q      <= cnt_d;
      lsh_q      <= lsh_d;
      rx_sh_q    <= rx_sh_d;
      rxbit_q    <= rxbit_d;
      io_o_q     <= io_o_d;
      io_oe_q    <= io_oe_d;
      gap_q      <= gap_d;
      sclk_q     <= sclk_d;
      cs_n_q     <= cs_n_d;
      rx_data_q  <= rx_data_d;
      rx_valid_q <= rx_valid_d;
      done_q     <= done_d;
    end
  end

  assign link.cs_n       = cs_n_q;
  assign link.sclk       = sclk_q;
  assign link.host_io_o  = io_o_q;
  assign link.host_io_oe = io_oe_q;
  assign ready           = (st_q == H_IDLE);
  assign rx_data         = rx_data_q;
  assign rx_valid        = rx_valid_q;
  assign done            = done_q;
endmodule : flash_id_host
`default_nettype wire

// ---- testbench/flash_link_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_link_sva (
  // clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // link
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] host_io_o,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] io
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> cs_n && !sclk && dev_io_oe == 4'h0)
    else $error("link not idle after reset");
  a_sclk_in_frame: assert property ($rose(sclk) |-> !cs_n)
    else $error("clock edge outside frame");
  a_no_contention: assert property ((dev_io_oe & host_io_oe) == 4'h0)
    else $error("both ends drive a lane");
  a_dev_quiet: assert property (cs_n [*6] |-> dev_io_oe == 4'h0)
    else $error("device drives while deselected");
  a_frame_start: assert property ($fell(cs_n) |-> dev_io_oe == 4'h0)
    else $error("device drives at frame start");
  a_lane_shape: assert property (dev_io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("bad device lane set");
  a_data_hold: assert property (sclk [*6] |-> $stable(dev_io_o))
    else $error("device data moved while clock high");
  a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*7])
    else $error("select high gap too short");
  a_shift_on_fall: assert property ($changed(dev_io_o) |-> !sclk)
    else $error("device data moved while clock high");
  c_quad: cover property (dev_io_oe == 4'hF);
  c_dual: cover property (dev_io_oe == 4'h3);
  c_single: cover property (dev_io_oe == 4'h2);
endmodule : flash_link_sva
`default_nettype wire

// ---- testbench/test_flash_resume_powerdown_id.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_flash_resume_powerdown_id;
  import flash_cmd_pkg::*;
  // arbitrary id values
  localparam logic [7:0]  MFR = 8'h5A;
  localparam logic [7:0]  DEV = 8'hC3;
  localparam logic [63:0] UID = 64'hFEDC_BA98_7654_3210;
  logic mclk = 0, sys_rst = 1, start = 0, engine_busy = 0, power_lost = 0;
  logic [7:0] op = 8'h00, mode_bits = 8'h00, rx_bytes = 8'h00, rx_data;
  logic [23:0] addr = 24'h0;
  logic ready, rx_valid, done, suspend_req, resume_req, suspend_flag, powered_down;
  logic [7:0] rxq[$];
  int n_errors = 0, checks = 0, n_res = 0, n_sus = 0, cyc = 0;
  // shortened timers; T_SHORT is shared by both ends, T_SUS goes to the host only
  localparam int T_SHORT = 20;
  localparam int T_SUS   = 40;
  flash_link_if lnk ();
  flash_id_host #(.TDP_CYCLES(T_SHORT), .RELEASE_TIME_CYCLES(T_SHORT), .RELEASE_WITH_ID_TIME_CYCLES(T_SHORT),
    .SUSPEND_LATENCY_TIME_CYCLES(T_SUS))
    i_flash_id_host (.mclk(mclk), .sys_rst(sys_rst), .link(lnk.host), .start(start), .op(op),
    .addr(addr), .mode_bits(mode_bits), .rx_bytes(rx_bytes), .ready(ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .done(done));
  flash_id_dev #(.MFR_ID(MFR), .DEV_ID(DEV), .UNIQUE_ID(UID), .TDP_CYCLES(T_SHORT),
    .RELEASE_TIME_CYCLES(T_SHORT), .RELEASE_WITH_ID_TIME_CYCLES(T_SHORT)) i_flash_id_dev (.mclk(mclk),
    .sys_rst(sys_rst),
    .link(lnk.dev), .engine_busy(engine_busy), .power_lost(power_lost),
    .suspend_req(suspend_req), .resume_req(resume_req), .suspend_flag(suspend_flag),
    .powered_down(powered_down));
  flash_link_sva i_flash_link_sva (.mclk(mclk), .sys_rst(sys_rst), .cs_n(lnk.cs_n),
    .sclk(lnk.sclk), .host_io_o(lnk.host_io_o), .host_io_oe(lnk.host_io_oe),
    .dev_io_o(lnk.dev_io_o), .dev_io_oe(lnk.dev_io_oe), .io(lnk.io));
  initial forever #4 mclk = ~mclk;
  // sample design outputs away from the edge that launches them
  always @(negedge mclk) begin
    cyc <= cyc + 1;
    if (rx_valid) rxq.push_back(rx_data);
    if (resume_req) n_res <= n_res + 1;
    if (suspend_req) n_sus <= n_sus + 1;
    if (cyc == 60000) begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] o, input logic [7:0] n);
    int k;
    rxq.delete();
    @(negedge mclk);
    op = o;
    addr = (o == OP_ID_QUAD || o == 8'h91) ? 24'h1 : 24'h0;
    rx_bytes = n;
    mode_bits = 8'hF0;
    start = 1;
    @(negedge mclk);
    start = 0;
    chk({7'h0, ready}, 8'h00);
    k = 0;
    while (done !== 1'b1 && k < 20000) begin
      @(negedge mclk);
      k++;
    end
    chk({7'h0, done}, 8'h01);
    chk({7'h0, ready}, 8'h01);
    repeat (8) @(negedge mclk);
  endtask : cmd
  task automatic rd(input logic [7:0] o, input logic [7:0] n, input logic [63:0] e);
    cmd(o, n);
    for (int i = 0; i < n; i++) chk(rxq[i], e[63-8*i -: 8]);
  endtask : rd
  task automatic t_ids;
    rd(OP_ID, 4, {MFR, DEV, MFR, DEV, 32'h0});
    rd(OP_ID_DUAL, 3, {MFR, DEV, MFR, 40'h0});
    rd(OP_ID_QUAD, 3, {DEV, MFR, DEV, 40'h0});
    rd(OP_RELEASE, 3, {DEV, DEV, DEV, 40'h0});
    rd(OP_UID, 8, UID);
    $display("test ids done");
  endtask : t_ids
  task automatic t_pdown;
    chk({7'h0, powered_down}, 8'h00);
    cmd(OP_PDOWN, 0);
    chk({7'h0, powered_down}, 8'h01);
    rd(OP_ID, 1, {8'hFF, 56'h0});
    cmd(OP_RELEASE, 0);
    chk({7'h0, powered_down}, 8'h00);
    cmd(OP_PDOWN, 0);
    rd(OP_RELEASE, 2, {DEV, DEV, 48'h0});
    rd(OP_ID, 1, {MFR, 56'h0});
    $display("test power-down done");
  endtask : t_pdown
  task automatic t_resume;
    cmd(OP_RESUME, 0);
    chk(8'(n_res), 8'h00);
    engine_busy = 1;
    cmd(OP_SUSPEND, 0);
    chk({7'h0, suspend_flag}, 8'h01);
    chk(8'(n_sus), 8'h01);
    cmd(OP_RESUME, 0);
    chk(8'(n_res), 8'h00);
    engine_busy = 0;
    cmd(OP_RESUME, 0);
    chk(8'(n_res), 8'h01);
    chk({7'h0, suspend_flag}, 8'h00);
    engine_busy = 1;
    rd(OP_RELEASE, 1, {8'hFF, 56'h0});
    cmd(OP_SUSPEND, 0);
    chk(8'(n_sus), 8'h02);
    engine_busy = 0;
    power_lost = 1;
    @(negedge mclk);
    power_lost = 0;
    chk({7'h0, suspend_flag}, 8'h00);
    cmd(OP_RESUME, 0);
    chk(8'(n_res), 8'h01);
    $display("test resume done");
  endtask : t_resume
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (3) @(negedge mclk);
    sys_rst = 0;
    t_ids();
    t_pdown();
    t_resume();
    end_sim();
  end
endmodule : test_flash_resume_powerdown_id
`default_nettype wire
